// file: hdl/lbs_defines.vh
// shared constants for the logic block table selector
`ifndef LBS_DEFINES_VH
`define LBS_DEFINES_VH

// condition result codes
`define LBS_CND_FALSE       2'h0
`define LBS_CND_TRUE        2'h1
`define LBS_CND_ERROR       2'h2
`define LBS_CND_NA          2'h3

// combining operator codes
`define LBS_OP_DEFAULT      3'h0
`define LBS_OP_AND3         3'h1
`define LBS_OP_OR3          3'h2
`define LBS_OP_AND12_OR3    3'h3
`define LBS_OP_OR12_AND3    3'h4

// selected table numbers
`define LBS_TBL_A           2'h1
`define LBS_TBL_B           2'h2
`define LBS_TBL_C           2'h3

// register byte offsets
`define LBS_REG_ENABLE      8'h00
`define LBS_REG_OPER        8'h04
`define LBS_REG_MAP         8'h08
`define LBS_REG_LUT_CFG     8'h0c
`define LBS_REG_SELECTED    8'h10
`define LBS_REG_OUT01       8'h14
`define LBS_REG_OUT23       8'h18
`define LBS_REG_EC_DATA     8'h1c
`define LBS_REG_EC_MIN      8'h20
`define LBS_REG_EC_MAX      8'h24

// reset values
`define LBS_OPER_RST        9'h009
`define LBS_MAP_RST13       9'h0d1
`define LBS_MAP_RST24       9'h1ac
`define LBS_OUT_NA          16'hffff

`endif

// file: hdl/lbs_block_eval.v
// one logic block: operator decode and ordered table choice
`timescale 1ns/1ps
`include "lbs_defines.vh"

module lbs_block_eval (
   // conditions, three per table, table A in the low bits
   input  wire [17:0] cond,
   // operators, table A in the low bits
   input  wire [8:0]  oper,
   // chosen table number 1..3
   output reg  [1:0]  sel_tbl
);

   // ==========================================
   // qualify one table
   function qualifies;
      input [5:0] c;
      input [2:0] op;
      reg t1, t2, t3, a1, a2, a3;
      begin
         t1 = (c[1:0] == `LBS_CND_TRUE);
         t2 = (c[3:2] == `LBS_CND_TRUE);
         t3 = (c[5:4] == `LBS_CND_TRUE);
         // n/a counts as true only for all-and
         a1 = t1 | (c[1:0] == `LBS_CND_NA);
         a2 = t2 | (c[3:2] == `LBS_CND_NA);
         a3 = t3 | (c[5:4] == `LBS_CND_NA);
         case (op) // RULE_01 RULE_17
            `LBS_OP_DEFAULT:   qualifies = 1'b1;           // RULE_03
            `LBS_OP_AND3:      qualifies = a1 & a2 & a3;   // RULE_04
            `LBS_OP_OR3:       qualifies = t1 | t2 | t3;   // RULE_05
            `LBS_OP_AND12_OR3: qualifies = (t1 & t2) | t3; // RULE_06
            `LBS_OP_OR12_AND3: qualifies = (t1 | t2) & t3; // RULE_07
            default:           qualifies = 1'b0;
         endcase
      end
   endfunction

   // ==========================================
   // first qualifying table wins
   always @* begin
      if (qualifies(cond[5:0], oper[2:0]))                // RULE_18
         sel_tbl = `LBS_TBL_A;                            // RULE_08
      else if (qualifies(cond[11:6], oper[5:3]))
         sel_tbl = `LBS_TBL_B;
      else if (qualifies(cond[17:12], oper[8:6]))
         sel_tbl = `LBS_TBL_C;
      else
         sel_tbl = `LBS_TBL_A;                            // RULE_09
   end

endmodule

// file: hdl/lbs_selector.v
// logic block table selector with avalon-mm register slave
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "lbs_defines.vh"

// Function
// (RULE_01) operator codes: default, and, or, mixes
// (RULE_02) reset: A,B all-and; C default table
// (RULE_03) default table selected without checking conditions
// (RULE_04) all-and: false/error reject, n/a passes
// (RULE_05) all-or: any true selects
// (RULE_06) (c1 and c2) or c3 selects
// (RULE_07) (c1 or c2) and c3 selects
// (RULE_08) first true table wins, rest skipped
// (RULE_09) nothing qualifies: table A chosen
// (RULE_10) software should put default last
// (RULE_11) selected table number readable, kept current
// (RULE_12) six-table mapping per table, reset defaults
// (RULE_13) unconfigured lookup table gives not available
// (RULE_14) configured lookup table output passes through
// (RULE_15) output percent with one decimal digit
// (RULE_16) extra control data routed with scaling limits
// (RULE_17) condition codes false,true,error,n/a
// (RULE_18) evaluate A, then B, then C
// (RULE_19) four blocks, enables cleared at reset
// (RULE_20) selection rerun and registered every cycle
// (RULE_21) reset shows table A and not available
module lbs_selector #(
   parameter NBLK = 4
) (
   // clock and reset
   input  wire                clock,
   input  wire                reset_n,
   // avalon-mm slave
   input  wire [7:0]          avs_address,
   input  wire                avs_read,
   input  wire                avs_write,
   input  wire [31:0]         avs_writedata,
   output reg  [31:0]         avs_readdata,
   output reg                 avs_waitrequest,
   // condition results, block-major, 18 bits each
   input  wire [18*NBLK-1:0]  condition_results,
   // lookup table unit outputs, 16 bits each, percent x10
   input  wire [16*6-1:0]     lookup_table_unit_value,
   // extra control input from process data
   input  wire [15:0]         extra_control_input,
   input  wire                extra_control_valid,
   // per block results
   output reg  [2*NBLK-1:0]   selected_table,
   output reg  [16*NBLK-1:0]  logic_block_output,
   // extra control routed to function blocks
   output reg  [15:0]         extra_control_out
);

   // ==========================================
   // configuration registers
   reg  [3:0]  enable_r;
   reg  [35:0] oper_all_r;
   reg  [35:0] map_all_r;
   reg  [5:0]  lut_cfg_r;
   reg  [15:0] ec_min_r;
   reg  [15:0] ec_max_r;
   reg         ack_r;

   wire        bus_req = (avs_read | avs_write) & ~ack_r;
   // writes land only at the edge the master sees waitrequest low
   wire        wr_ack  = avs_write & ~avs_waitrequest;
   wire [1:0]  blk_sel = avs_writedata[31:30];

   // ==========================================
   // register writes; one wait cycle then ack
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         enable_r   <= 4'h0;                                            // RULE_19
         oper_all_r <= {4{`LBS_OPER_RST}};                              // RULE_02
         map_all_r  <= {`LBS_MAP_RST24, `LBS_MAP_RST13, `LBS_MAP_RST24, `LBS_MAP_RST13}; // RULE_12
         lut_cfg_r  <= 6'h00;
         ec_min_r   <= 16'h0000;
         ec_max_r   <= 16'hffff;
         ack_r      <= 1'b0;
      end else begin
         ack_r <= bus_req;
         if (wr_ack) begin
            if (avs_address == `LBS_REG_ENABLE)
               enable_r <= avs_writedata[3:0];
            else if (avs_address == `LBS_REG_OPER) begin
               case (blk_sel)
                  2'h0: oper_all_r[8:0]   <= avs_writedata[8:0];
                  2'h1: oper_all_r[17:9]  <= avs_writedata[8:0];
                  2'h2: oper_all_r[26:18] <= avs_writedata[8:0];
                  default: oper_all_r[35:27] <= avs_writedata[8:0];
               endcase
            end else if (avs_address == `LBS_REG_MAP) begin
               case (blk_sel)
                  2'h0: map_all_r[8:0]   <= avs_writedata[8:0];
                  2'h1: map_all_r[17:9]  <= avs_writedata[8:0];
                  2'h2: map_all_r[26:18] <= avs_writedata[8:0];
                  default: map_all_r[35:27] <= avs_writedata[8:0];
               endcase
            end else if (avs_address == `LBS_REG_LUT_CFG)
               lut_cfg_r <= avs_writedata[5:0];
            else if (avs_address == `LBS_REG_EC_MIN)
               ec_min_r <= avs_writedata[15:0];
            else if (avs_address == `LBS_REG_EC_MAX)
               ec_max_r <= avs_writedata[15:0];
         end
      end
   end

   // ==========================================
   // per block evaluation
   wire [1:0] sel_w [0:3];
   reg  [15:0] lut_val [0:5];
   integer k;
   always @* begin
      for (k = 0; k < 6; k = k + 1)
         lut_val[k] = lookup_table_unit_value[16*k +: 16];
   end

   genvar g;
   generate
      for (g = 0; g < NBLK; g = g + 1) begin : blk
         wire [1:0]  tbl;
         wire [2:0]  lut_num;
         lbs_block_eval u_eval (
            .cond    (condition_results[18*g +: 18]),
            .oper    (oper_all_r[9*g +: 9]),
            .sel_tbl (tbl)
         );
         // lookup table number 1..6 for the chosen table
         assign lut_num = map_all_r[9*g + 3*(tbl - 2'h1) +: 3];
         always @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               selected_table[2*g +: 2]      <= `LBS_TBL_A;             // RULE_21
               logic_block_output[16*g +: 16] <= `LBS_OUT_NA;
            end else if (enable_r[g]) begin                              // RULE_20
               selected_table[2*g +: 2] <= tbl;                          // RULE_11
               if (lut_num == 3'h0 || lut_num > 3'h6 || !lut_cfg_r[lut_num - 3'h1])
                  logic_block_output[16*g +: 16] <= `LBS_OUT_NA;         // RULE_13
               else
                  logic_block_output[16*g +: 16] <= lut_val[lut_num - 3'h1]; // RULE_14 RULE_15
            end
         end
      end
   endgenerate

   // ==========================================
   // extra control clamped to its scaling limits
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         extra_control_out <= 16'h0000;
      else if (extra_control_valid) begin                               // RULE_16
         if (extra_control_input < ec_min_r)
            extra_control_out <= ec_min_r;
         else if (extra_control_input > ec_max_r)
            extra_control_out <= ec_max_r;
         else
            extra_control_out <= extra_control_input;
      end
   end

   // ==========================================
   // read path and waitrequest
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata    <= 32'h00000000;
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~bus_req;
         if (avs_read && bus_req) begin
            if (avs_address == `LBS_REG_ENABLE)
               avs_readdata <= {28'h0000000, enable_r};
            else if (avs_address == `LBS_REG_OPER)
               avs_readdata <= {28'h0000000, oper_all_r[35:32]} | 32'h0 | {5'h00, oper_all_r[26:0]};
            else if (avs_address == `LBS_REG_MAP)
               avs_readdata <= {5'h00, map_all_r[26:0]};
            else if (avs_address == `LBS_REG_LUT_CFG)
               avs_readdata <= {26'h0000000, lut_cfg_r};
            else if (avs_address == `LBS_REG_SELECTED)
               avs_readdata <= {24'h000000, selected_table};
            else if (avs_address == `LBS_REG_OUT01)
               avs_readdata <= logic_block_output[31:0];
            else if (avs_address == `LBS_REG_OUT23)
               avs_readdata <= logic_block_output[63:32];
            else if (avs_address == `LBS_REG_EC_DATA)
               avs_readdata <= {16'h0000, extra_control_out};
            else if (avs_address == `LBS_REG_EC_MIN)
               avs_readdata <= {16'h0000, ec_min_r};
            else if (avs_address == `LBS_REG_EC_MAX)
               avs_readdata <= {16'h0000, ec_max_r};
            else
               avs_readdata <= 32'h00000000;
         end
      end
   end

endmodule

// file: sim/lbs_sel_assertions.sv
// port assertions for the table selector
`timescale 1ns/1ps
module lbs_sel_assertions #(
   parameter NBLK = 4
) (
   // clock and reset
   input wire                clock,
   input wire                reset_n,
   // register bus
   input wire [7:0]          avs_address,
   input wire                avs_read,
   input wire                avs_write,
   input wire [31:0]         avs_writedata,
   input wire [31:0]         avs_readdata,
   input wire                avs_waitrequest,
   // data
   input wire [16*6-1:0]     lookup_table_unit_value,
   input wire [2*NBLK-1:0]   selected_table,
   input wire [16*NBLK-1:0]  logic_block_output
);
   // ====================
   // shadow of block 0 enable and unit config
   reg        en_r;
   reg [5:0]  lut_r;
   reg [95:0] lutq_r;
   reg        hit;
   integer    i;
   wire       wack = avs_write && !avs_waitrequest;
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         en_r <= 1'b0;
         lut_r <= 6'h00;
         lutq_r <= 96'h0;
      end else begin
         lutq_r <= lookup_table_unit_value;
         if (wack && avs_address == 8'h00)
            en_r <= avs_writedata[0];
         if (wack && avs_address == 8'h0c)
            lut_r <= avs_writedata[5:0];
      end
   end
   // output must be not-available or one of the unit values seen last cycle
   always @* begin
      hit = logic_block_output[15:0] == 16'hffff;
      for (i = 0; i < 6; i = i + 1)
         hit = hit || logic_block_output[15:0] == lutq_r[16*i +: 16];
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   wait_ack_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
      else $error("bus answer late");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   ack_cause_a: assert property (!avs_waitrequest |-> avs_read || avs_write)
      else $error("answer without request");
   sel_range_a: assert property (selected_table[1:0] != 2'h0)
      else $error("selected table out of range");
   frozen_a: assert property (!en_r |=> $stable(selected_table[1:0]))
      else $error("disabled block changed");
   unmapped_rd_a: assert property (avs_read && !avs_waitrequest && avs_address >= 8'h28 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   na_out_a: assert property (en_r && lut_r == 6'h00 |=> logic_block_output[15:0] == 16'hffff)
      else $error("output not n/a");
   out_pass_a: assert property (en_r |=> hit)
      else $error("output not a unit value");
endmodule
bind lbs_selector lbs_sel_assertions #(.NBLK(NBLK)) chk_u (.clock, .reset_n, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .lookup_table_unit_value,
   .selected_table, .logic_block_output);

// file: sim/lbs_partner.sv
// condition evaluators and lookup units feeding the selector
`timescale 1ns/1ps
module lbs_partner (
   input wire         clock,
   input wire [71:0]  cond_req,
   input wire [95:0]  lut_req,
   output reg [71:0]  condition_results,
   output reg [95:0]  lookup_table_unit_value
);
   // ====================
   initial condition_results = 72'h0;
   initial lookup_table_unit_value = 96'h0;
   // results settle one edge after the bench asks for them
   always @(posedge clock) begin
      condition_results <= cond_req;
      lookup_table_unit_value <= lut_req;
   end
endmodule

// file: sim/logic_block_table_selector_test.sv
// self-checking bench for the table selector
`timescale 1ns/1ps
module logic_block_table_selector_test;
   // ====================
   reg         clock, reset_n, avs_read, avs_write;
   reg  [7:0]  avs_address;
   reg  [31:0] avs_writedata, q;
   reg  [71:0] cr, cn;
   reg  [95:0] lr, ln;
   reg  [35:0] ops;
   reg  [5:0]  cfg;
   reg  [7:0]  sv;
   reg  [15:0] ecin;
   reg         ecv;
   wire [15:0] eco;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest;
   wire [71:0] cres;
   wire [95:0] lval;
   wire [7:0]  sel;
   wire [63:0] lbo;
   integer     err_count, n_checks, it, g, e, u;
   lbs_selector #(.NBLK(4)) dut_u (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .condition_results(cres),
      .lookup_table_unit_value(lval), .extra_control_input(ecin), .extra_control_valid(ecv),
      .selected_table(sel), .logic_block_output(lbo), .extra_control_out(eco));
   lbs_partner ptn_u (.clock(clock), .cond_req(cr), .lut_req(lr), .condition_results(cres),
      .lookup_table_unit_value(lval));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task chk(input string nm, input [31:0] s, input [31:0] x);
      n_checks = n_checks + 1;
      if (s !== x) begin
         err_count = err_count + 1;
         $display("mismatch %s expected %h seen %h", nm, x, s);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one bus cycle; request held until waitrequest is seen low
   task bus(input w, input [7:0] a, input [31:0] d);
      integer n;
      n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do begin
         @(posedge clock);
         n = n + 1;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20) begin
         err_count = err_count + 1;
         wrap_up;
      end
   endtask
   function q1(input [5:0] c, input [2:0] op);
      reg a, b, d;
      begin
         a = c[1:0] == 2'h1;
         b = c[3:2] == 2'h1;
         d = c[5:4] == 2'h1;
         case (op)
            3'h0: q1 = 1'b1;
            3'h1: q1 = c[0] && c[2] && c[4];
            3'h2: q1 = a || b || d;
            3'h3: q1 = (a && b) || d;
            3'h4: q1 = (a || b) && d;
            default: q1 = 1'b0;
         endcase
      end
   endfunction
   // first qualifying table wins, table A when none does
   function integer pick(input [17:0] c, input [8:0] op);
      integer t;
      begin
         pick = 1;
         for (t = 2; t >= 0; t = t - 1)
            if (q1(c[6*t +: 6], op[3*t +: 3]))
               pick = t + 1;
      end
   endfunction
   initial begin
      err_count = 0;
      n_checks = 0;
      reset_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      cr = 72'h0;
      lr = 96'h0;
      ecin = 16'h0000;
      ecv = 1'b0;
      ops = {4{9'h009}};
      it = $urandom(29133);
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      bus(0, 8'h10, 0); chk("selected", q, 32'h55);
      bus(0, 8'h14, 0); chk("output", q, 32'hffffffff);
      bus(0, 8'h18, 0); chk("output hi", q, 32'hffffffff);
      bus(0, 8'h20, 0); chk("ec min", q, 0);
      bus(0, 8'h24, 0); chk("ec max", q, 32'hffff);
      bus(0, 8'h00, 0); chk("enable", q[3:0], 0);
      bus(0, 8'h04, 0); chk("oper", q[26:0], {3{9'h009}});
      bus(0, 8'h08, 0); chk("map", q[26:0], {9'h0d1, 9'h1ac, 9'h0d1});
      bus(1, 8'h40, 32'h1);
      bus(0, 8'h40, 0); chk("unmapped", q, 0);
      bus(1, 8'h00, 32'hf);
      for (it = 0; it < 60; it = it + 1) begin
         // first ten rounds keep the reset operators
         for (g = 0; g < 4 && it >= 10; g = g + 1) begin
            ops[9*g +: 9] = (it % 7 == 0) ? 9'h049 : {3'($urandom % 5), 3'($urandom % 5), 3'($urandom % 5)};
            bus(1, 8'h04, {g[1:0], 21'h0, ops[9*g +: 9]});
         end
         cfg = $urandom;
         bus(1, 8'h0c, {26'h0, cfg});
         cn = {$urandom, $urandom, $urandom};
         ln = {$urandom, $urandom, $urandom};
         @(posedge clock);
         cr <= cn;
         lr <= ln;
         repeat (4) @(posedge clock);
         #1;
         for (g = 0; g < 4; g = g + 1) begin
            e = pick(cn[18*g +: 18], ops[9*g +: 9]);
            u = (g % 2) * 3 + e - 1;
            chk("table", sel[2*g +: 2], e);
            chk("value", lbo[16*g +: 16], cfg[u] ? ln[16*u +: 16] : 16'hffff);
         end
      end
      // extra control clamped to written limits, edges included
      bus(1, 8'h20, 32'h100);
      bus(1, 8'h24, 32'h200);
      for (it = 0; it < 8; it = it + 1) begin
         u = (it == 0) ? 32'h200 : (it == 1) ? 32'h100 : $urandom % 32'h300;
         e = (u < 32'h100) ? 32'h100 : (u > 32'h200) ? 32'h200 : u;
         @(posedge clock);
         ecin <= u[15:0];
         ecv <= 1'b1;
         @(posedge clock);
         ecv <= 1'b0;
         repeat (2) @(posedge clock);
         #1;
         chk("extra", eco, e);
      end
      bus(0, 8'h1c, 0); chk("extra rd", q, e);
      sv = sel;
      bus(1, 8'h00, 32'h0);
      @(posedge clock);
      cr <= ~cn;
      repeat (4) @(posedge clock);
      #1;
      chk("frozen", sel, sv);
      wrap_up;
   end
endmodule
